// ---- ssc_top.sv ----
// Start-up switch decoder, card sequencer and port setup
//
// The placing of the registers and register access over Avalon-MM were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Position 1 on blocks user program writes
// - Position 1 also guards parameters and blocks clears
// - Position 2 at start-up loads from card
// - Position 7 restore beats position 2 load
// - Position 4 on: peripheral uses stored setup
// - Position 5 on: serial port auto-detects
// - Peripheral tries console, then ascending rates
// - Non-bus devices and 51,200 go undetected
// - Serial tries only bus rates, ascending
// - Position 6 mirrored into user switch flag
// - Position 7 plus hold writes card
// - Position 7 at power-up restores card
// - Position 7 off plus hold verifies card
// - After restore, stay in program mode
// - Host link refused on peripheral, 4 off
// - Host link refused on serial, 5 on
module ssc_top
   import ssc_pkg::*;
#(
   parameter int HOLD_CYCLES = HOLD_CYC // Button hold count
)(
   input  wire logic        clk,
   input  wire logic        srst,
   // Operator pins
   input  wire logic [7:0]  sw_pin,
   input  wire logic        card_btn_pin,
   // Avalon-MM slave
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // Program memory guards
   input  wire logic        um_wr_req,
   output logic             um_wr_en,
   input  wire logic        param_wr_req,
   output logic             param_wr_en,
   input  wire logic        mem_clr_req,
   output logic             mem_clr_go,
   // Memory card
   output logic [2:0]       card_cmd,
   output logic             card_start,
   input  wire logic        card_done,
   // Operating mode
   input  wire logic [1:0]  mode_req,
   input  wire logic        mode_req_valid,
   output logic [1:0]       op_mode,
   output logic             mode_refused,
   // Serial ports
   input  wire logic        per_try_fail,
   input  wire logic        per_link_ok,
   input  wire logic        ser_try_fail,
   input  wire logic        ser_link_ok,
   output logic             per_use_setup,
   output logic             ser_use_setup,
   output logic [2:0]       per_step,
   output logic [2:0]       ser_step,
   output logic             per_locked,
   output logic             ser_locked,
   output logic             per_hostlink_ok,
   output logic             ser_hostlink_ok,
   // Program-visible flag
   output logic             user_switch_flag
);
   // ***************************************************
   // Declarations
   // ***************************************************
   logic [8:0]  sync1;       // First stage, read by sync2 only
   logic [8:0]  sync2;       // Second stage
   logic [8:0]  sync3;       // Third stage
   logic [8:0]  stable;      // Agreed pin levels
   logic [7:0]  sw;          // Stable switches
   logic        btn;         // Stable pushbutton
   logic        lat_autold;  // Position 2 at power-up
   logic        lat_periph;  // Position 4 at power-up
   logic        lat_serial;  // Position 5 at power-up
   logic        lat_backup;  // Position 7 at power-up
   ssc_state_t  state;       // Sequencer state
   logic [2:0]  settle_cnt;  // Synchroniser fill wait
   logic [29:0] hold_cnt;    // Pushbutton hold timer
   logic        hold_fired;  // One operation per press
   logic        hold_hit;    // Hold time reached
   logic        restore_lock; // Program mode pinned
   logic [1:0]  ctrl;        // Detect enables
   logic        ack;         // Bus answer cycle

   // ***************************************************
   // Pin synchronisers
   // ***************************************************
   // Three stages; taken once stages two and three agree
   always_ff @(posedge clk) begin
      if (srst) begin
         sync1  <= 9'h000;
         sync2  <= 9'h000;
         sync3  <= 9'h000;
         stable <= 9'h000;
      end else begin
         sync1 <= {card_btn_pin, sw_pin};
         sync2 <= sync1;
         sync3 <= sync2;
         for (int i = 0; i < 9; i++) begin
            if (sync2[i] == sync3[i]) begin
               stable[i] <= sync3[i];
            end
         end
      end
   end

   assign sw  = stable[7:0];
   assign btn = stable[8];

   // ***************************************************
   // Write protection
   // ***************************************************
   // Live switch: protection works while running
   assign um_wr_en    = um_wr_req && !sw[SW_PROTECT];
   assign param_wr_en = param_wr_req && !sw[SW_PROTECT];
   assign mem_clr_go  = mem_clr_req && !sw[SW_PROTECT];

   // ***************************************************
   // User switch flag
   // ***************************************************
   always_ff @(posedge clk) begin
      if (srst) begin
         user_switch_flag <= 1'b0;
      end else begin
         user_switch_flag <= sw[SW_USER];
      end
   end

   // ***************************************************
   // Power-up sample
   // ***************************************************
   // Once, after the synchronisers fill
   always_ff @(posedge clk) begin
      if (srst) begin
         lat_autold <= 1'b0;
         lat_periph <= 1'b0;
         lat_serial <= 1'b0;
         lat_backup <= 1'b0;
      end else if (state == ST_LATCH) begin
         lat_autold <= sw[SW_AUTOLD];
         lat_periph <= sw[SW_PERIPH];
         lat_serial <= sw[SW_SERIAL];
         lat_backup <= sw[SW_BACKUP];
      end
   end

   // ***************************************************
   // Pushbutton hold timer
   // ***************************************************
   // Once per press; a long press never repeats
   always_ff @(posedge clk) begin
      if (srst || !btn) begin
         hold_cnt   <= 30'h0;
         hold_fired <= 1'b0;
      end else if (hold_hit) begin
         hold_fired <= 1'b1;
      end else if (!hold_fired) begin
         hold_cnt <= 30'(hold_cnt + 30'h1);
      end
   end

   assign hold_hit = btn && !hold_fired
                     && hold_cnt == 30'(HOLD_CYCLES - 1);

   // ***************************************************
   // Start-up and card sequencer
   // ***************************************************
   always_ff @(posedge clk) begin
      if (srst) begin
         state      <= ST_SETTLE;
         settle_cnt <= 3'h0;
         card_cmd   <= CARD_NONE;
         card_start <= 1'b0;
      end else begin
         card_start <= 1'b0;
         case (state)
            ST_SETTLE: begin
               // No action before the pins are trusted
               settle_cnt <= 3'(settle_cnt + 3'h1);
               if (settle_cnt == 3'(SETTLE_CYC - 1)) begin
                  state <= ST_LATCH;
               end
            end
            ST_LATCH: begin
               if (sw[SW_BACKUP]) begin
                  // Restore wins over automatic load
                  card_cmd   <= CARD_RESTORE;
                  card_start <= 1'b1;
                  state      <= ST_WAIT;
               end else if (sw[SW_AUTOLD]) begin
                  card_cmd   <= CARD_LOAD;
                  card_start <= 1'b1;
                  state      <= ST_WAIT;
               end else begin
                  state <= ST_IDLE;
               end
            end
            ST_IDLE: begin
               // Backup or verify chosen by live position 7
               if (hold_hit) begin
                  card_cmd   <= sw[SW_BACKUP] ? CARD_BACKUP
                                : CARD_VERIFY;
                  card_start <= 1'b1;
                  state      <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               // Presses during an operation are dropped
               if (card_done) begin
                  card_cmd <= CARD_NONE;
                  state    <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ***************************************************
   // Operating mode
   // ***************************************************
   // Lock stays until the next power cycle (srst)
   always_ff @(posedge clk) begin
      if (srst) begin
         restore_lock <= 1'b0;
         op_mode      <= MODE_PROG;
         mode_refused <= 1'b0;
      end else begin
         mode_refused <= 1'b0;
         if (card_start && card_cmd == CARD_RESTORE) begin
            restore_lock <= 1'b1;
            op_mode      <= MODE_PROG;
         end else if (mode_req_valid) begin
            if (restore_lock && mode_req != MODE_PROG) begin
               mode_refused <= 1'b1;
            end else if (mode_req <= MODE_RUN) begin
               op_mode <= mode_req;
            end else begin
               mode_refused <= 1'b1;
            end
         end
      end
   end

   // ***************************************************
   // Port setup selection
   // ***************************************************
   // Power-up values; a change needs a power cycle
   assign per_use_setup   = lat_periph;
   assign ser_use_setup   = !lat_serial;
   assign per_hostlink_ok = lat_periph;
   assign ser_hostlink_ok = !lat_serial;

   // Peripheral port detector, console first
   ssc_detect u_per_detect (
      .clk          (clk),
      .srst         (srst),
      .run          (!lat_periph && ctrl[0] && state != ST_SETTLE && state != ST_LATCH),
      .with_console (1'b1),
      .try_fail     (per_try_fail),
      .link_ok      (per_link_ok),
      .step         (per_step),
      .locked       (per_locked)
   );

   // Serial port detector, bus rates only
   ssc_detect u_ser_detect (
      .clk          (clk),
      .srst         (srst),
      .run          (lat_serial && ctrl[1] && state != ST_SETTLE),
      .with_console (1'b0),
      .try_fail     (ser_try_fail),
      .link_ok      (ser_link_ok),
      .step         (ser_step),
      .locked       (ser_locked)
   );

   // ***************************************************
   // Avalon-MM slave
   // ***************************************************
   // One wait cycle: answer at the second edge of a request
   assign avs_waitrequest = (avs_read || avs_write) && !ack;

   always_ff @(posedge clk) begin
      if (srst) begin
         ack <= 1'b0;
      end else begin
         ack <= (avs_read || avs_write) && !ack;
      end
   end

   // Control register write; unmapped writes are ignored
   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl <= CTRL_RST;
      end else if (avs_write && ack && avs_address == OFF_CTRL) begin
         ctrl <= avs_writedata[1:0];
      end
   end

   // Read data prepared in the wait cycle; unmapped reads zero
   always_ff @(posedge clk) begin
      if (srst) begin
         avs_readdata <= 32'h0;
      end else if (avs_read && !ack) begin
         case (avs_address)
            OFF_STATUS: avs_readdata <= {13'h0, card_cmd,
               restore_lock, op_mode, lat_backup, lat_serial,
               lat_periph, lat_autold, btn, sw};
            OFF_CTRL:   avs_readdata <= {30'h0, ctrl};
            OFF_DETECT: avs_readdata <= {24'h0, ser_locked,
               ser_step, per_locked, per_step};
            default:    avs_readdata <= 32'h0;
         endcase
      end
   end

   // ***************************************************
   // Checks
   // ***************************************************
   um_guard_a: assert property (
      @(posedge clk) disable iff (srst)
      sw[SW_PROTECT] |-> !um_wr_en)
      else $error("program write passed while protected");
   clr_guard_a: assert property (
      @(posedge clk) disable iff (srst)
      sw[SW_PROTECT] |-> !mem_clr_go && !param_wr_en)
      else $error("clear or parameter write while protected");
   autoload_a: assert property (
      @(posedge clk) disable iff (srst)
      state == ST_LATCH && sw[SW_AUTOLD] && !sw[SW_BACKUP]
      |=> card_start && card_cmd == CARD_LOAD)
      else $error("automatic load not started");
   no_load_a: assert property (
      @(posedge clk) disable iff (srst)
      lat_backup |-> !(card_start && card_cmd == CARD_LOAD))
      else $error("load started with restore selected");
   user_flag_a: assert property (
      @(posedge clk) disable iff (srst)
      ##1 user_switch_flag == $past(sw[SW_USER]))
      else $error("user switch flag not mirrored");
   hold_op_a: assert property (
      @(posedge clk) disable iff (srst)
      state == ST_IDLE && hold_hit
      |=> card_start && card_cmd ==
          ($past(sw[SW_BACKUP]) ? CARD_BACKUP : CARD_VERIFY))
      else $error("hold did not start backup or verify");
   prog_lock_a: assert property (
      @(posedge clk) disable iff (srst)
      restore_lock |-> op_mode == MODE_PROG)
      else $error("mode left program after restore");
   host_link_a: assert property (
      @(posedge clk) disable iff (srst)
      state == ST_LATCH |=> per_hostlink_ok == $past(sw[SW_PERIPH])
      && ser_hostlink_ok == !$past(sw[SW_SERIAL]))
      else $error("host link permission mismatch");
   bus_answer_a: assert property (
      @(posedge clk) disable iff (srst)
      (avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest)
      else $error("bus answer later than one wait");

   restore_c: cover property (@(posedge clk) disable iff (srst)
      card_start && card_cmd == CARD_RESTORE);
   backup_c: cover property (@(posedge clk) disable iff (srst)
      card_start && card_cmd == CARD_BACKUP);
   refused_c: cover property (@(posedge clk) disable iff (srst)
      mode_refused && restore_lock);
   per_lock_c: cover property (@(posedge clk) disable iff (srst)
      per_locked && per_step == STEP_115200);
endmodule : ssc_top
`default_nettype wire

// ---- ssc_pkg.sv ----
// Constants of the start-up switch decoder
package ssc_pkg;
   // ***************************************************
   // Register map (byte addresses)
   // ***************************************************
   localparam logic [3:0] OFF_STATUS = 4'h0; // Switch and card state
   localparam logic [3:0] OFF_CTRL   = 4'h4; // Detect enables
   localparam logic [3:0] OFF_DETECT = 4'h8; // Detect steps and locks
   localparam logic [1:0] CTRL_RST   = 2'h3; // Both detectors enabled

   // ***************************************************
   // Switch positions (0-based bit index)
   // ***************************************************
   localparam int SW_PROTECT = 0; // Position 1
   localparam int SW_AUTOLD  = 1; // Position 2
   localparam int SW_PERIPH  = 3; // Position 4
   localparam int SW_SERIAL  = 4; // Position 5
   localparam int SW_USER    = 5; // Position 6
   localparam int SW_BACKUP  = 6; // Position 7

   // ***************************************************
   // Timing
   // ***************************************************
   localparam int SETTLE_CYC  = 4;      // Synchroniser fill
   localparam int HOLD_TIME_MS = 3000;  // Pushbutton hold
   localparam int CLK_KHZ     = 250000; // 250 MHz clock
   localparam int HOLD_CYC    = HOLD_TIME_MS * CLK_KHZ;

   // ***************************************************
   // Card operations, modes, detect steps
   // ***************************************************
   localparam logic [2:0] CARD_NONE    = 3'h0;
   localparam logic [2:0] CARD_RESTORE = 3'h1;
   localparam logic [2:0] CARD_LOAD    = 3'h2;
   localparam logic [2:0] CARD_BACKUP  = 3'h3;
   localparam logic [2:0] CARD_VERIFY  = 3'h4;
   localparam logic [1:0] MODE_PROG    = 2'h0;
   localparam logic [1:0] MODE_MON     = 2'h1;
   localparam logic [1:0] MODE_RUN     = 2'h2;
   localparam logic [2:0] STEP_CONSOLE = 3'h0;
   localparam logic [2:0] STEP_9600    = 3'h1;
   localparam logic [2:0] STEP_19200   = 3'h2;
   localparam logic [2:0] STEP_38400   = 3'h3;
   localparam logic [2:0] STEP_115200  = 3'h4;

   // Sequencer states
   typedef enum logic [2:0] {
      ST_SETTLE, ST_LATCH, ST_IDLE, ST_WAIT
   } ssc_state_t;
endpackage : ssc_pkg

// ---- ssc_detect.sv ----
// Baud-rate auto-detect stepper for one serial port
`timescale 1ns/10ps
`default_nettype none
module ssc_detect
   import ssc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       run,          // Auto-detect active
   input  wire logic       with_console, // Console step first
   input  wire logic       try_fail,     // Attempt failed, pulse
   input  wire logic       link_ok,      // Attempt matched, pulse
   output logic [2:0]      step,         // Current attempt
   output logic            locked        // Device found
);
   logic [2:0] first_step; // First attempt of a cycle

   // Console only on the peripheral port
   assign first_step = with_console ? STEP_CONSOLE : STEP_9600;

   // ***************************************************
   // Stepper
   // ***************************************************
   // Ascending rates, then wrap; the 51,200 rate is no step
   always_ff @(posedge clk) begin
      if (srst || !run) begin
         step   <= first_step;
         locked <= 1'b0;
      end else if (!locked) begin
         if (link_ok) begin
            locked <= 1'b1;
         end else if (try_fail) begin
            // Other speeds never match, so keep cycling
            step <= (step == STEP_115200) ? first_step
                    : 3'(step + 3'h1);
         end
      end
   end

   // ***************************************************
   // Checks
   // ***************************************************
   step_order_a: assert property (
      @(posedge clk) disable iff (srst)
      run && !locked && try_fail && !link_ok && step != STEP_115200
      |=> step == $past(step) + 3'h1)
      else $error("detect step not ascending");
   no_console_a: assert property (
      @(posedge clk) disable iff (srst)
      !with_console |-> step != STEP_CONSOLE)
      else $error("console step on serial port");
endmodule : ssc_detect
`default_nettype wire

// ---- ssc_far_model.sv ----
// Far-side model: memory card and devices on both ports
`timescale 1ns/10ps
`default_nettype none
module ssc_far_model
#(
   parameter int CARD_LAT = 5            // Card busy cycles
)(
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       card_start,
   output logic            card_done,
   input  wire logic [2:0] per_step,
   input  wire logic [2:0] per_dev,      // Device rate, 7 never matches
   output logic            per_try_fail,
   output logic            per_link_ok,
   input  wire logic [2:0] ser_step,
   input  wire logic [2:0] ser_dev,      // Device rate, 7 never matches
   output logic            ser_try_fail,
   output logic            ser_link_ok
);
   int         card_cnt;                 // Card job cycles left
   logic [1:0] tick;                     // Attempt pacing
   // ***************************************************
   // Card: done pulse a fixed time after start
   // ***************************************************
   always_ff @(posedge clk) begin
      card_done <= 1'b0;
      if (srst) begin
         card_cnt <= 0;
      end else if (card_start) begin
         card_cnt <= CARD_LAT;
      end else if (card_cnt > 0) begin
         card_cnt  <= card_cnt - 1;
         card_done <= card_cnt == 1;
      end
   end
   // ***************************************************
   // Devices: answer every fourth cycle
   // ***************************************************
   // Only its own rate matches; any other step fails
   always_ff @(posedge clk) begin
      tick         <= srst ? 2'h0 : tick + 2'h1;
      per_link_ok  <= !srst && tick == 2'h3 && per_step == per_dev;
      per_try_fail <= !srst && tick == 2'h3 && per_step != per_dev;
      ser_link_ok  <= !srst && tick == 2'h3 && ser_step == ser_dev;
      ser_try_fail <= !srst && tick == 2'h3 && ser_step != ser_dev;
   end
endmodule : ssc_far_model
`default_nettype wire

// ---- ssc_top_tb.sv ----
// Self-checking bench for the start-up switch decoder
`timescale 1ns/10ps
`default_nettype none
module ssc_top_tb
   import ssc_pkg::*;
;
   localparam int HOLD = 20;             // Short hold for simulation
   logic        clk = 1'b0;
   logic        srst, card_btn_pin, avs_read, avs_write, card_done, mode_req_valid;
   logic        um_wr_req, param_wr_req, mem_clr_req, um_wr_en, param_wr_en, mem_clr_go;
   logic        per_try_fail, per_link_ok, ser_try_fail, ser_link_ok, mode_refused;
   logic        per_use_setup, ser_use_setup, per_locked, ser_locked, card_start;
   logic        per_hostlink_ok, ser_hostlink_ok, user_switch_flag, avs_waitrequest;
   logic [7:0]  sw_pin;
   logic [3:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd, s;
   logic [1:0]  mode_req, op_mode;
   logic [2:0]  card_cmd, per_step, ser_step, per_dev, ser_dev, per_prev, ser_prev, last_cmd;
   logic [31:0] seed = 32'h4356;         // Fixed seed keeps runs repeatable
   logic        mon_on = 1'b1;           // Step order watch enabled
   logic        ref_f;
   int          num_errors = 0;
   int          checks = 0;
   int          cyc = 0;
   int          ncard = 0;               // Card jobs started
   int          n0;

   always #2 clk = ~clk;                 // 250 MHz

   ssc_top #(.HOLD_CYCLES(HOLD)) dut_u (
      .clk(clk), .srst(srst), .sw_pin(sw_pin), .card_btn_pin(card_btn_pin),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .um_wr_req(um_wr_req), .um_wr_en(um_wr_en),
      .param_wr_req(param_wr_req), .param_wr_en(param_wr_en), .mem_clr_req(mem_clr_req),
      .mem_clr_go(mem_clr_go), .card_cmd(card_cmd), .card_start(card_start),
      .card_done(card_done), .mode_req(mode_req), .mode_req_valid(mode_req_valid),
      .op_mode(op_mode), .mode_refused(mode_refused), .per_try_fail(per_try_fail),
      .per_link_ok(per_link_ok), .ser_try_fail(ser_try_fail), .ser_link_ok(ser_link_ok),
      .per_use_setup(per_use_setup), .ser_use_setup(ser_use_setup), .per_step(per_step),
      .ser_step(ser_step), .per_locked(per_locked), .ser_locked(ser_locked),
      .per_hostlink_ok(per_hostlink_ok), .ser_hostlink_ok(ser_hostlink_ok),
      .user_switch_flag(user_switch_flag));

   ssc_far_model far_u (
      .clk(clk), .srst(srst), .card_start(card_start), .card_done(card_done),
      .per_step(per_step), .per_dev(per_dev), .per_try_fail(per_try_fail),
      .per_link_ok(per_link_ok), .ser_step(ser_step), .ser_dev(ser_dev),
      .ser_try_fail(ser_try_fail), .ser_link_ok(ser_link_ok));
   // ***************************************************
   // Helpers
   // ***************************************************
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr

   // Next attempt; serial has no console step
   function automatic logic [2:0] step_after(input logic [2:0] v, input logic con);
      return (v == STEP_115200) ? (con ? STEP_CONSOLE : STEP_9600) : v + 3'h1;
   endfunction : step_after

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic give_verdict;
      $display("checks=%0d num_errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : give_verdict

   // Hold the request until waitrequest is low at an edge
   task automatic bus_op(input logic wr, input logic [3:0] a, input logic [31:0] d);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      @(posedge clk);
   endtask : bus_op

   task automatic mode_try(input logic [1:0] m, output logic refused);
      mode_req       <= m;
      mode_req_valid <= 1'b1;
      @(posedge clk);
      mode_req_valid <= 1'b0;
      @(posedge clk);
      refused = mode_refused;
   endtask : mode_try

   // Pins steady across release for a clean sample
   task automatic power_up(input logic [7:0] sw);
      sw_pin <= sw;
      srst   <= 1'b1;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      repeat (20) @(posedge clk);
   endtask : power_up
   // ***************************************************
   // Monitors: timeout, card starts, detect step order
   // ***************************************************
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         num_errors++;
         give_verdict();
      end
      if (card_start === 1'b1) begin
         ncard++;
         last_cmd = card_cmd;
      end
      if (mon_on && !srst && per_step !== per_prev) begin
         chk(32'(per_step), 32'(step_after(per_prev, 1'b1)));
      end
      if (mon_on && !srst && ser_step !== ser_prev) begin
         chk(32'(ser_step), 32'(step_after(ser_prev, 1'b0)));
      end
      per_prev = per_step;
      ser_prev = ser_step;
   end
   // ***************************************************
   // Main sequence
   // ***************************************************
   initial begin
      {srst, card_btn_pin, avs_read, avs_write, mode_req_valid} = '0;
      {um_wr_req, param_wr_req, mem_clr_req, mode_req, avs_address} = '0;
      {avs_writedata, per_prev, ser_prev, last_cmd, sw_pin} = '0;
      per_dev = STEP_CONSOLE;
      ser_dev = STEP_9600;
      // Load at start-up, both ports on stored setup
      power_up(8'h0a);
      chk(32'(last_cmd), 32'(CARD_LOAD));
      chk({per_use_setup, ser_use_setup, per_hostlink_ok, ser_hostlink_ok}, 32'hf);
      chk({per_locked, ser_locked}, 32'h0);
      mode_try(MODE_RUN, ref_f);
      chk({ref_f, op_mode}, {30'h0, MODE_RUN});
      mode_try(2'h3, ref_f);
      chk({ref_f, op_mode}, {30'h1, MODE_RUN});
      $display("test load_startup done");
      // Restore beats load, both ports auto-detect
      per_dev <= STEP_38400;
      ser_dev <= 3'h7;
      power_up(8'h52);
      chk(32'(last_cmd), 32'(CARD_RESTORE));
      chk({per_use_setup, ser_use_setup, per_hostlink_ok, ser_hostlink_ok}, 32'h0);
      for (int m = 1; m < 3; m++) begin
         mode_try(2'(m), ref_f);
         chk({ref_f, op_mode}, {30'h1, MODE_PROG});
      end
      repeat (120) @(posedge clk);
      chk({per_locked, per_step, ser_locked}, {28'h1, STEP_38400, 1'b0});
      sw_pin <= 8'h20;
      repeat (8) @(posedge clk);
      bus_op(1'b0, OFF_STATUS, 32'h0);
      chk(rd[15:0], {7'b1001101, 1'b0, 8'h20});
      $display("test restore_detect done");
      // Live protect and user flag, two corners then random
      for (int i = 0; i < 16; i++) begin
         seed = lfsr(seed);
         s = (i == 0) ? 32'h701 : (i == 1) ? 32'h700 : seed;
         sw_pin <= {1'b0, s[6:0]};
         {um_wr_req, param_wr_req, mem_clr_req} <= s[10:8];
         repeat (6) @(posedge clk);
         chk({um_wr_en, param_wr_en, mem_clr_go, user_switch_flag},
             {28'h0, s[10:8] & {3{~s[0]}}, s[5]});
      end
      $display("test protect_random done");
      // Held button: backup if position 7 on, else verify
      for (int b = 1; b >= 0; b--) begin
         sw_pin <= b[0] ? 8'h40 : 8'h00;
         repeat (6) @(posedge clk);
         n0 = ncard;
         card_btn_pin <= 1'b1;
         for (int w = 0; w < 100 && ncard == n0; w++) @(posedge clk);
         card_btn_pin <= 1'b0;
         chk(32'(last_cmd), b[0] ? 32'(CARD_BACKUP) : 32'(CARD_VERIFY));
         repeat (12) @(posedge clk);
      end
      n0 = ncard;
      card_btn_pin <= 1'b1;
      repeat (HOLD - 8) @(posedge clk);
      card_btn_pin <= 1'b0;
      repeat (40) @(posedge clk);
      chk(ncard, n0);
      $display("test card_button done");
      // Registers: reset, write, read-only, unmapped
      mon_on = 1'b0;
      bus_op(1'b0, OFF_CTRL, 32'h0);
      chk(rd, {30'h0, CTRL_RST});
      bus_op(1'b1, OFF_CTRL, 32'h0);
      bus_op(1'b0, OFF_CTRL, 32'h0);
      chk(rd, 32'h0);
      bus_op(1'b0, OFF_DETECT, 32'h0);
      chk({rd[7], rd[3]}, 32'h0);
      bus_op(1'b1, OFF_STATUS, 32'hffff_ffff);
      bus_op(1'b0, OFF_STATUS, 32'h0);
      chk(rd[7:0], 32'h0);
      bus_op(1'b0, 4'hc, 32'h0);
      chk(rd, 32'h0);
      $display("test registers done");
      give_verdict();
   end
endmodule : ssc_top_tb
`default_nettype wire
